/* fifo_ctrl.sv */
`timescale 1ns/10ps
// Contract
// R1 - memory acts as single or two-rate queue
// R2 - push logic on push rate, pop on pop
// R3 - direction bit swaps push and pop roles
// R4 - user flushes after changing direction
// R5 - push and pop widths x9/x18/x36 independent
// R6 - four-bit level code per side
// R7 - popped data leaves through pipeline register
// R8 - async flush polarity is selectable
// R9 - push request stores input word
// R10 - pop request returns oldest word
// R11 - almost full at one free entry
// R12 - almost empty at one used entry
// R13 - push codes full, empty, half, quarter, 64
// R14 - push codes 32 down to 1 free
// R15 - pop codes empty through 32 entries
// R16 - pop codes 64, quarter, half, full
// R17 - async flush clears control immediately
// R18 - one or two blocks, depth by width
// R19 - side flushes cross to other side
// R20 - flags held while flush crosses, two ticks
// R21 - async flush unfiltered on both pointers
// R22 - push when full, pop when empty ignored
// R23 - single-rate mode skips crossing stages
module fifo_ctrl
	import fifo_ctrl_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, low active
	input wire logic [11:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic push_ce, // push side rate enable
	input wire logic push_req, // push request
	input wire logic push_flush, // push side flush
	input wire logic [DATA_W-1:0] din, // push data
	input wire logic pop_ce, // pop side rate enable
	input wire logic pop_req, // pop request
	input wire logic pop_flush, // pop side flush
	input wire logic async_flush, // asynchronous flush pin
	output logic [DATA_W-1:0] dout, // popped data
	output logic dout_valid, // dout loaded this cycle
	output logic almost_full, // one free entry left
	output logic almost_empty, // one entry used
	output logic [3:0] push_flag, // push level code
	output logic [3:0] pop_flag // pop level code
);
	// configuration and bus state, reset by presetn only
	typedef struct packed {
		logic [7:0] ctrl; // control register
		logic [31:0] prdata; // read data for access phase
		logic pready; // ready flop
		logic pslverr; // error flop
	} cfg_t;

	// queue state, also cleared by the async flush
	typedef struct packed {
		logic [PTR_W-1:0] wptr; // push pointer, 9-bit units
		logic [PTR_W-1:0] rptr; // pop pointer, 9-bit units
		logic [PTR_W-1:0] rs1; // pop pointer seen by push side
		logic [PTR_W-1:0] rs2;
		logic [PTR_W-1:0] ws1; // push pointer seen by pop side
		logic [PTR_W-1:0] ws2;
		logic fw1; // push flush crossing to pop side
		logic fw2;
		logic fr1; // pop flush crossing to push side
		logic fr2;
		logic rd_pend; // memory read under way
		logic [1:0] rd_lane; // lane of the pending read
		logic [1:0] rd_sel; // width of the pending read
		logic [DATA_W-1:0] dout; // output pipeline register
		logic dout_valid;
		logic [3:0] push_flag;
		logic [3:0] pop_flag;
		logic af;
		logic ae;
	} queue_t;

	cfg_t cfg_reg, cfg_next; // bus side state
	queue_t q_reg, q_next; // queue side state
	logic clr_n; // combined async clear
	logic [DATA_W-1:0] ram_rdata; // word from memory
	logic ram_we; // memory write
	logic [WORD_ADDR_W-1:0] ram_waddr;
	logic [3:0] ram_lane;
	logic [DATA_W-1:0] ram_wdata;
	logic ram_re; // memory read
	logic [WORD_ADDR_W-1:0] ram_raddr;

	// storage units per access for a width select
	function automatic logic [PTR_W-1:0] units(input logic [1:0] s);
		case (s)
			WSEL_X18: units = LVL_2;
			WSEL_X36: units = LVL_4;
			default: units = LVL_1;
		endcase
	endfunction

	// units to words of the given width
	function automatic logic [PTR_W-1:0] words(input logic [PTR_W-1:0] u, input logic [1:0] s);
		case (s)
			WSEL_X18: words = u >> 1;
			WSEL_X36: words = u >> 2;
			default: words = u;
		endcase
	endfunction

	// push level code from free words and depth in words
	function automatic logic [3:0] push_code(input logic [PTR_W-1:0] room, input logic [PTR_W-1:0] depth);
		if (room == '0) begin
			push_code = PUSH_FULL; // R13
		end else if (room == depth) begin
			push_code = PUSH_EMPTY; // R13
		end else if (room > (depth >> 1)) begin
			push_code = PUSH_HALF; // R13
		end else if (room > (depth >> 2)) begin
			push_code = PUSH_QUARTER; // R13
		end else if (room >= LVL_64) begin
			push_code = PUSH_64; // R13
		end else if (room >= LVL_32) begin
			push_code = PUSH_32; // R14
		end else if (room >= LVL_16) begin
			push_code = PUSH_16; // R14
		end else if (room >= LVL_8) begin
			push_code = PUSH_8; // R14
		end else if (room >= LVL_4) begin
			push_code = PUSH_4; // R14
		end else if (room >= LVL_2) begin
			push_code = PUSH_2; // R14
		end else begin
			push_code = PUSH_1; // R14
		end
	endfunction

	// pop level code from used words and depth in words
	function automatic logic [3:0] pop_code(input logic [PTR_W-1:0] used, input logic [PTR_W-1:0] depth);
		if (used == '0) begin
			pop_code = POP_EMPTY; // R15
		end else if (used == depth) begin
			pop_code = POP_FULL; // R16
		end else if (used >= (depth >> 1)) begin
			pop_code = POP_HALF; // R16
		end else if (used >= (depth >> 2)) begin
			pop_code = POP_QUARTER; // R16
		end else if (used >= LVL_64) begin
			pop_code = POP_64; // R16
		end else if (used >= LVL_32) begin
			pop_code = POP_32; // R15
		end else if (used >= LVL_16) begin
			pop_code = POP_16; // R15
		end else if (used >= LVL_8) begin
			pop_code = POP_8; // R15
		end else if (used >= LVL_4) begin
			pop_code = POP_4; // R15
		end else if (used >= LVL_2) begin
			pop_code = POP_2; // R15
		end else begin
			pop_code = POP_1; // R15
		end
	endfunction

	// async flush with chosen polarity, straight onto the clear, no filter
	assign clr_n = presetn & ~(async_flush ^ cfg_reg.ctrl[CTRL_POL_BIT]); // R8 R17 R21

	// role swap and per-side views
	logic async_mode, dir; // mode bits
	logic [1:0] wsel, rsel; // side widths
	logic [PTR_W-1:0] cap, cap_mask; // capacity in units
	logic push_tick, push_rq, push_fl; // effective push side
	logic pop_tick, pop_rq, pop_fl; // effective pop side
	logic busy; // a side flush is crossing
	logic [PTR_W-1:0] push_used, pop_used, push_room; // fill seen per side
	logic push_ok, pop_ok; // accepted requests

	always_comb begin
		async_mode = cfg_reg.ctrl[CTRL_ASYNC_BIT]; // R1
		dir = cfg_reg.ctrl[CTRL_DIR_BIT];
		wsel = cfg_reg.ctrl[CTRL_PUSH_W_LSB +: 2]; // R5
		rsel = cfg_reg.ctrl[CTRL_POP_W_LSB +: 2]; // R5
		cap = cfg_reg.ctrl[CTRL_TWO_BLK_BIT] ? CAP_TWO_BLOCKS : CAP_ONE_BLOCK; // R18
		cap_mask = cap - LVL_1;
		push_tick = dir ? pop_ce : push_ce; // R3
		push_rq = dir ? pop_req : push_req; // R3
		push_fl = dir ? pop_flush : push_flush; // R3
		pop_tick = dir ? push_ce : pop_ce; // R3
		pop_rq = dir ? push_req : pop_req; // R3
		pop_fl = dir ? push_flush : pop_flush; // R3
		busy = q_reg.fw1 | q_reg.fw2 | q_reg.fr1 | q_reg.fr2;
		// in two-rate mode each side sees the other pointer through its own stages
		push_used = q_reg.wptr - (async_mode ? q_reg.rs2 : q_reg.rptr); // R2 R23
		pop_used = (async_mode ? q_reg.ws2 : q_reg.wptr) - q_reg.rptr; // R2 R23
		push_room = cap - push_used;
		push_ok = push_tick & push_rq & ~push_fl & ~busy & (push_room >= units(wsel)); // R22
		pop_ok = pop_tick & pop_rq & ~pop_fl & ~busy & (pop_used >= units(rsel)); // R22
	end

	// memory port control, one aligned word per access
	always_comb begin
		ram_we = push_ok; // R9
		ram_waddr = WORD_ADDR_W'((q_reg.wptr & cap_mask) >> 2);
		case (wsel)
			WSEL_X18: begin
				ram_lane = q_reg.wptr[1] ? 4'hc : 4'h3;
				ram_wdata = {din[17:0], din[17:0]};
			end
			WSEL_X36: begin
				ram_lane = 4'hf;
				ram_wdata = din;
			end
			default: begin
				ram_lane = 4'h1 << q_reg.wptr[1:0];
				ram_wdata = {4{din[8:0]}};
			end
		endcase
		ram_re = pop_ok; // R10
		ram_raddr = WORD_ADDR_W'((q_reg.rptr & cap_mask) >> 2);
	end

	fifo_ram u_ram (
		.clk(pclk),
		.wr_en(ram_we),
		.wr_addr(ram_waddr),
		.wr_lane(ram_lane),
		.wr_data(ram_wdata),
		.rd_en(ram_re),
		.rd_addr(ram_raddr),
		.rd_data(ram_rdata)
	);

	// apb slave: decode in setup, answer in the first access cycle
	always_comb begin
		cfg_next = cfg_reg;
		cfg_next.pready = psel & ~penable;
		if (psel & ~penable) begin
			case (paddr)
				CTRL_OFFSET: begin
					cfg_next.prdata = {24'h000000, cfg_reg.ctrl};
					cfg_next.pslverr = 1'b0;
				end
				STATUS_OFFSET: begin
					cfg_next.prdata = {8'h00, pop_used, 1'b0, busy, q_reg.ae, q_reg.af,
						q_reg.pop_flag, q_reg.push_flag};
					cfg_next.pslverr = 1'b0;
				end
				default: begin
					cfg_next.prdata = 32'h00000000;
					cfg_next.pslverr = 1'b1;
				end
			endcase
		end
		// write lands at the completing edge
		if (psel & penable & cfg_reg.pready & pwrite & pstrb[0] & (paddr == CTRL_OFFSET)) begin
			cfg_next.ctrl = pwdata[7:0];
		end
	end

	// queue pointers, crossing stages, flags and read pipeline
	always_comb begin
		q_next = q_reg;
		// push side
		if (push_ok) begin
			q_next.wptr = q_reg.wptr + units(wsel); // R9
		end
		// pop side
		if (pop_ok) begin
			q_next.rptr = q_reg.rptr + units(rsel); // R10
		end
		q_next.rd_pend = pop_ok;
		if (pop_ok) begin
			q_next.rd_lane = q_reg.rptr[1:0];
			q_next.rd_sel = rsel;
		end
		// output register one stage after the memory read
		q_next.dout_valid = q_reg.rd_pend; // R7
		if (q_reg.rd_pend) begin
			case (q_reg.rd_sel)
				WSEL_X18: q_next.dout = {18'h00000, q_reg.rd_lane[1] ? ram_rdata[35:18] : ram_rdata[17:0]}; // R7
				WSEL_X36: q_next.dout = ram_rdata; // R7
				default: q_next.dout = {27'h0000000, ram_rdata[q_reg.rd_lane*9 +: 9]}; // R7
			endcase
		end
		// pointer copies advance on the receiving side's tick
		if (push_tick) begin
			q_next.rs1 = q_reg.rptr; // R2
			q_next.rs2 = q_reg.rs1;
		end
		if (pop_tick) begin
			q_next.ws1 = q_reg.wptr; // R2
			q_next.ws2 = q_reg.ws1;
		end
		// flags refresh on own tick, held while a flush crosses
		if (push_tick & ~busy) begin
			q_next.push_flag = push_code(words(push_room, wsel), words(cap, wsel)); // R6 R20
			q_next.af = (words(push_room, wsel) == LVL_1); // R11
		end
		if (pop_tick & ~busy) begin
			q_next.pop_flag = pop_code(words(pop_used, rsel), words(cap, rsel)); // R6 R20
			q_next.ae = (words(pop_used, rsel) == LVL_1); // R12
		end
		// side flushes
		if (!async_mode) begin
			if ((push_tick & push_fl) | (pop_tick & pop_fl)) begin
				q_next = '0; // R23
				q_next.push_flag = PUSH_EMPTY;
				q_next.pop_flag = POP_EMPTY;
				q_next.dout = q_reg.dout;
			end
		end else begin
			// push flush: clear push pointer, pass over two pop ticks
			if (push_tick & push_fl & ~busy) begin
				q_next.wptr = '0; // R19
				q_next.fw1 = 1'b1;
			end
			if (pop_tick & q_reg.fw1) begin
				q_next.fw2 = 1'b1; // R19 R20
			end
			if (pop_tick & q_reg.fw2) begin
				q_next.rptr = '0; // R19
				q_next.fw1 = 1'b0;
				q_next.fw2 = 1'b0;
				q_next.rd_pend = 1'b0;
				q_next.ae = 1'b0;
				// almost full stays with push_flag until the next push tick
				q_next.pop_flag = POP_EMPTY;
			end
			// pop flush: clear pop pointer, pass over two push ticks
			if (pop_tick & pop_fl & ~busy) begin
				q_next.rptr = '0; // R19
				q_next.rd_pend = 1'b0;
				q_next.fr1 = 1'b1;
			end
			if (push_tick & q_reg.fr1) begin
				q_next.fr2 = 1'b1; // R19 R20
			end
			if (push_tick & q_reg.fr2) begin
				q_next.wptr = '0; // R19
				q_next.fr1 = 1'b0;
				q_next.fr2 = 1'b0;
				// almost empty stays with pop_flag until the next pop tick
				q_next.af = 1'b0;
				q_next.push_flag = PUSH_EMPTY;
			end
			// both pointers now zero: copies restart from zero too
			if ((pop_tick & q_reg.fw2) | (push_tick & q_reg.fr2)) begin
				q_next.rs1 = '0;
				q_next.rs2 = '0;
				q_next.ws1 = '0;
				q_next.ws2 = '0;
			end
		end
	end

	// bus side registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg.ctrl <= CTRL_RESET;
			cfg_reg.prdata <= 32'h00000000;
			cfg_reg.pready <= 1'b0;
			cfg_reg.pslverr <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// queue registers, cleared at once by reset or async flush
	always_ff @(posedge pclk or negedge clr_n) begin
		if (!clr_n) begin
			q_reg <= '0; // R17 R21
			q_reg.push_flag <= PUSH_EMPTY;
			q_reg.pop_flag <= POP_EMPTY;
		end else begin
			q_reg <= q_next;
		end
	end

	// outputs straight from flops
	assign prdata = cfg_reg.prdata;
	assign pready = cfg_reg.pready;
	assign pslverr = cfg_reg.pslverr;
	assign dout = q_reg.dout;
	assign dout_valid = q_reg.dout_valid;
	assign almost_full = q_reg.af;
	assign almost_empty = q_reg.ae;
	assign push_flag = q_reg.push_flag;
	assign pop_flag = q_reg.pop_flag;
endmodule

/* fifo_ctrl_pkg.sv */
package fifo_ctrl_pkg;
	// register map, byte addresses on the apb bus
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	// control register fields
	localparam int CTRL_ASYNC_BIT = 0; // 1: two-rate operation
	localparam int CTRL_DIR_BIT = 1; // 1: push and pop roles swapped
	localparam int CTRL_POL_BIT = 2; // 1: async flush active low
	localparam int CTRL_PUSH_W_LSB = 3; // push width select, 2 bits
	localparam int CTRL_POP_W_LSB = 5; // pop width select, 2 bits
	localparam int CTRL_TWO_BLK_BIT = 7; // 1: two memory blocks cascaded
	localparam logic [7:0] CTRL_RESET = 8'h80;
	// width select codes
	localparam logic [1:0] WSEL_X9 = 2'h0;
	localparam logic [1:0] WSEL_X18 = 2'h1;
	localparam logic [1:0] WSEL_X36 = 2'h2;
	// data and storage geometry, storage counted in 9-bit units
	localparam int DATA_W = 36;
	localparam int PTR_W = 12;
	localparam int WORD_ADDR_W = 9;
	localparam logic [11:0] CAP_ONE_BLOCK = 12'h400;
	localparam logic [11:0] CAP_TWO_BLOCKS = 12'h800;
	localparam logic [11:0] LVL_64 = 12'h040;
	localparam logic [11:0] LVL_32 = 12'h020;
	localparam logic [11:0] LVL_16 = 12'h010;
	localparam logic [11:0] LVL_8 = 12'h008;
	localparam logic [11:0] LVL_4 = 12'h004;
	localparam logic [11:0] LVL_2 = 12'h002;
	localparam logic [11:0] LVL_1 = 12'h001;
	// push side level codes
	localparam logic [3:0] PUSH_FULL = 4'h0;
	localparam logic [3:0] PUSH_EMPTY = 4'h1;
	localparam logic [3:0] PUSH_HALF = 4'h2;
	localparam logic [3:0] PUSH_QUARTER = 4'h3;
	localparam logic [3:0] PUSH_64 = 4'h4;
	localparam logic [3:0] PUSH_32 = 4'ha;
	localparam logic [3:0] PUSH_16 = 4'hb;
	localparam logic [3:0] PUSH_8 = 4'hc;
	localparam logic [3:0] PUSH_4 = 4'hd;
	localparam logic [3:0] PUSH_2 = 4'he;
	localparam logic [3:0] PUSH_1 = 4'hf;
	// pop side level codes
	localparam logic [3:0] POP_EMPTY = 4'h0;
	localparam logic [3:0] POP_1 = 4'h1;
	localparam logic [3:0] POP_2 = 4'h2;
	localparam logic [3:0] POP_4 = 4'h3;
	localparam logic [3:0] POP_8 = 4'h4;
	localparam logic [3:0] POP_16 = 4'h5;
	localparam logic [3:0] POP_32 = 4'h6;
	localparam logic [3:0] POP_64 = 4'h8;
	localparam logic [3:0] POP_QUARTER = 4'hd;
	localparam logic [3:0] POP_HALF = 4'he;
	localparam logic [3:0] POP_FULL = 4'hf;
endpackage

/* fifo_ram.sv */
`timescale 1ns/10ps
// 512 x 36 storage, four 9-bit lanes, registered read data
module fifo_ram
	import fifo_ctrl_pkg::*;
(
	input wire logic clk, // pclk
	input wire logic wr_en, // write strobe
	input wire logic [WORD_ADDR_W-1:0] wr_addr, // word address
	input wire logic [3:0] wr_lane, // lane enables
	input wire logic [DATA_W-1:0] wr_data, // write word
	input wire logic rd_en, // read strobe
	input wire logic [WORD_ADDR_W-1:0] rd_addr, // word address
	output logic [DATA_W-1:0] rd_data // read word, one cycle later
);
	logic [DATA_W-1:0] mem [0:(1<<WORD_ADDR_W)-1]; // array, no reset

	// lane writes and registered read
	always_ff @(posedge clk) begin
		if (wr_en) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_lane[i]) begin
					mem[wr_addr][i*9 +: 9] <= wr_data[i*9 +: 9];
				end
			end
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* fifo_ctrl_monitor.sv */
`timescale 1ns/10ps
// checks apb timing and queue flags at the top ports
module fifo_ctrl_monitor
	import fifo_ctrl_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic [11:0] paddr, // address
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // direction
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic push_ce, // push port tick
	input wire logic push_req, // push port request
	input wire logic pop_ce, // pop port tick
	input wire logic pop_req, // pop port request
	input wire logic [DATA_W-1:0] dout, // popped word
	input wire logic dout_valid, // pop strobe
	input wire logic almost_full, // one free
	input wire logic almost_empty, // one used
	input wire logic [3:0] push_flag, // push code
	input wire logic [3:0] pop_flag // pop code
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// address decode and pop request on either port
	wire logic mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);
	wire logic any_pop = (push_ce && push_req) || (pop_ce && pop_req);
	a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_once: assert property (pready |-> psel && penable ##1 !pready) else $error("ready misplaced");
	a_err_map: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
	a_valid_cause: assert property (dout_valid |-> $past(any_pop, 2)) else $error("data without pop");
	a_dout_hold: assert property ($changed(dout) |-> dout_valid || dout == '0) else $error("data moved");
	a_full_code: assert property (almost_full == (push_flag == PUSH_1)) else $error("almost full wrong");
	a_empty_code: assert property (almost_empty == (pop_flag == POP_1)) else $error("almost empty wrong");
	a_push_legal: assert property (push_flag inside {[4'h0:4'h4], [4'ha:4'hf]}) else $error("push code");
	a_pop_legal: assert property (pop_flag inside {[4'h0:4'h6], 4'h8, [4'hd:4'hf]}) else $error("pop code");
	// main scenarios reached
	cover property (dout_valid);
	cover property (push_flag == PUSH_FULL);
	cover property (pready && pslverr);
endmodule
bind fifo_ctrl fifo_ctrl_monitor mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.push_ce(push_ce), .push_req(push_req), .pop_ce(pop_ce), .pop_req(pop_req), .dout(dout),
	.dout_valid(dout_valid), .almost_full(almost_full), .almost_empty(almost_empty),
	.push_flag(push_flag), .pop_flag(pop_flag));

/* fifo_ctrl_partner.sv */
`timescale 1ns/10ps
// user producer and consumer beside the queue
module fifo_ctrl_partner
	import fifo_ctrl_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic slow, // 1: random rate ticks
	input wire logic dir, // 1: roles swapped
	input wire logic [DATA_W-1:0] dout, // popped word
	input wire logic dout_valid, // pop strobe
	output logic push_ce, // push port tick
	output logic push_req, // push port request
	output logic [DATA_W-1:0] din, // push data
	output logic pop_ce, // pop port tick
	output logic pop_req // pop port request
);
	logic [DATA_W-1:0] tx_q[$]; // words to push
	logic [DATA_W-1:0] rx_q[$]; // words popped
	int rx_n = 0; // pops still wanted
	logic p_ce = 1'b0, p_req = 1'b0, c_ce = 1'b0, c_req = 1'b0; // two users
	logic [DATA_W-1:0] wd = '0; // producer word
	// requests held until a tick takes them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_ce <= 1'b0;
			p_req <= 1'b0;
			c_ce <= 1'b0;
			c_req <= 1'b0;
		end else begin
			if (p_ce && p_req) void'(tx_q.pop_front());
			if (c_ce && c_req) rx_n--;
			if (dout_valid) rx_q.push_back(dout);
			p_ce <= slow ? 1'($urandom) : 1'b1;
			c_ce <= slow ? 1'($urandom) : 1'b1;
			p_req <= tx_q.size() != 0;
			c_req <= rx_n > 0;
			wd <= (tx_q.size() != 0) ? tx_q[0] : ~wd;
		end
	end
	// role swap follows the direction bit
	assign din = wd;
	assign push_ce = dir ? c_ce : p_ce;
	assign push_req = dir ? c_req : p_req;
	assign pop_ce = dir ? p_ce : c_ce;
	assign pop_req = dir ? p_req : c_req;
endmodule

/* fifo_ctrl_bench.sv */
`timescale 1ns/10ps
// self-checking bench for the queue controller
module fifo_ctrl_bench
	import fifo_ctrl_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb side
	logic [11:0] paddr = '0; // address
	logic [31:0] pwdata = '0, prdata; // data
	logic pready, pslverr, push_ce, push_req, pop_ce, pop_req, dout_valid, almost_full, almost_empty;
	logic push_flush = 1'b0, pop_flush = 1'b0, async_flush = 1'b0, slow = 1'b0, dir = 1'b0; // controls
	logic [DATA_W-1:0] din, dout; // data
	logic [3:0] push_flag, pop_flag; // level codes
	logic [8:0] uq[$]; // expected stored units
	int errors = 0, check_count = 0;
	always #5 pclk = ~pclk;
	fifo_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.push_ce(push_ce), .push_req(push_req), .push_flush(push_flush), .din(din), .pop_ce(pop_ce),
		.pop_req(pop_req), .pop_flush(pop_flush), .async_flush(async_flush), .dout(dout),
		.dout_valid(dout_valid), .almost_full(almost_full), .almost_empty(almost_empty),
		.push_flag(push_flag), .pop_flag(pop_flag));
	fifo_ctrl_partner mate (.pclk(pclk), .presetn(presetn), .slow(slow), .dir(dir), .dout(dout),
		.dout_valid(dout_valid), .push_ce(push_ce), .push_req(push_req), .din(din), .pop_ce(pop_ce),
		.pop_req(pop_req));
	// verdict and end of run
	task test_done();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one comparison
	task chk(input string n, input logic [35:0] e, input logic [35:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// bounded wait ran out
	task tmo(input int k, input int lim);
		if (k >= lim) begin
			errors++;
			$display("unexpected timeout after %0d cycles", k);
			test_done();
		end
	endtask
	// one apb transfer, request held until ready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tmo(k, 20);
	endtask
	function int units(input logic [1:0] s);
		return s == WSEL_X36 ? 4 : s == WSEL_X18 ? 2 : 1;
	endfunction
	// expected push code from free words
	function logic [3:0] push_code(input int f, input int d);
		if (f == 0) return PUSH_FULL;
		if (f == d) return PUSH_EMPTY;
		if (f > d / 2) return PUSH_HALF;
		if (f > d / 4) return PUSH_QUARTER;
		if (f >= 64) return PUSH_64;
		if (f >= 32) return PUSH_32;
		if (f >= 16) return PUSH_16;
		if (f >= 8) return PUSH_8;
		if (f >= 4) return PUSH_4;
		return f >= 2 ? PUSH_2 : PUSH_1;
	endfunction
	// expected pop code from stored words
	function logic [3:0] pop_code(input int m, input int d);
		if (m == 0) return POP_EMPTY;
		if (m == d) return POP_FULL;
		if (m >= d / 2) return POP_HALF;
		if (m >= d / 4) return POP_QUARTER;
		if (m >= 64) return POP_64;
		if (m >= 32) return POP_32;
		if (m >= 16) return POP_16;
		if (m >= 8) return POP_8;
		if (m >= 4) return POP_4;
		return m >= 2 ? POP_2 : POP_1;
	endfunction
	// push side flush, held until both sides read empty
	task flush();
		int k;
		logic [31:0] r;
		logic e;
		@(posedge pclk);
		push_flush <= 1'b1;
		k = 0;
		while ((k < 8 || push_flag !== PUSH_EMPTY || pop_flag !== POP_EMPTY) && k < 200) begin
			@(posedge pclk);
			k++;
		end
		tmo(k, 200);
		push_flush <= 1'b0;
		k = 0;
		do begin
			apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
			k++;
		end while (r[10] !== 1'b0 && k < 30);
		tmo(k, 30);
	endtask
	// configure, fill with n words, check levels, drain and compare
	task run(input logic [1:0] pw, input logic [1:0] qw, input logic as, input logic dr, input logic blk, input int n);
		int k, pu, qu, cap, used, f, m;
		logic [31:0] r;
		logic e;
		logic [35:0] w;
		pu = units(pw);
		qu = units(qw);
		cap = blk ? CAP_TWO_BLOCKS : CAP_ONE_BLOCK;
		apb(1'b1, CTRL_OFFSET, {24'h0, blk, qw, pw, 1'b0, dr, as}, r, e);
		slow <= as;
		dir <= dr;
		flush();
		uq.delete();
		used = 0;
		for (int i = 0; i < n; i++) begin
			w = 36'({$urandom, $urandom});
			mate.tx_q.push_back(w);
			if (cap - used >= pu) begin
				for (int j = 0; j < pu; j++) uq.push_back(w[9*j +: 9]);
				used += pu;
			end
		end
		k = 0;
		while (mate.tx_q.size() != 0 && k < 9000) begin
			@(posedge pclk);
			k++;
		end
		tmo(k, 9000);
		f = (cap - used) / pu;
		m = used / qu;
		k = 0;
		while ((push_flag !== push_code(f, cap / pu) || pop_flag !== pop_code(m, cap / qu)) && k < 200) begin
			@(posedge pclk);
			k++;
		end
		chk("push level", push_code(f, cap / pu), push_flag);
		chk("pop level", pop_code(m, cap / qu), pop_flag);
		chk("almost full", f == 1, almost_full);
		chk("almost empty", m == 1, almost_empty);
		mate.rx_q.delete();
		mate.rx_n = m;
		k = 0;
		while (mate.rx_q.size() != m && k < 9000) begin
			@(posedge pclk);
			k++;
		end
		tmo(k, 9000);
		for (int i = 0; i < m; i++) begin
			w = '0;
			for (int j = 0; j < qu; j++) w[9*j +: 9] = uq.pop_front();
			chk("popped word", w, mate.rx_q[i]);
		end
	endtask
	// main sequence
	initial begin
		logic [31:0] r;
		logic e;
		int k;
		void'($urandom(32'ha9a9449c));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk("reset push level", PUSH_EMPTY, push_flag);
		chk("reset pop level", POP_EMPTY, pop_flag);
		apb(1'b0, CTRL_OFFSET, 32'h0, r, e);
		chk("ctrl reset", {24'h0, CTRL_RESET}, r);
		apb(1'b1, 12'h008, 32'hff, r, e);
		chk("unmapped write error", 1'b1, e);
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk("unmapped read data", {1'b1, 32'h0}, {e, r});
		apb(1'b1, STATUS_OFFSET, 32'hffff_ffff, r, e);
		apb(1'b0, STATUS_OFFSET, 32'h0, r, e);
		chk("status", 32'h1, r);
		run(WSEL_X36, WSEL_X36, 1'b0, 1'b0, 1'b1, 513);
		run(WSEL_X18, WSEL_X18, 1'b0, 1'b0, 1'b0, 513);
		run(WSEL_X9, WSEL_X9, 1'b1, 1'b0, 1'b1, 1);
		run(WSEL_X36, WSEL_X9, 1'b0, 1'b0, 1'b0, 255);
		for (int i = 0; i < 9; i++) run(2'(i / 3), 2'(i % 3), i[0], i == 4, 1'b1, 1 + $urandom % 80);
		async_flush <= 1'b1;
		#1;
		chk("dout on high flush", 36'h0, dout);
		apb(1'b1, CTRL_OFFSET, 32'h84, r, e);
		mate.tx_q = {36'h1, 36'h2, 36'h3};
		k = 0;
		while (push_flag !== PUSH_HALF && k < 50) begin
			@(posedge pclk);
			k++;
		end
		chk("level before flush", PUSH_HALF, push_flag);
		async_flush <= 1'b0;
		#1;
		chk("flags on async flush", {PUSH_EMPTY, POP_EMPTY}, {push_flag, pop_flag});
		test_done();
	end
endmodule
